// ### hw/dcf_pkg.sv
// Shared constants of the sixteen-thousand-word eighteen-bit first-in first-out buffer.
package dcf_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int          DATA_W       = 18;
    localparam int          FIFO_DEPTH   = 16384;
    localparam int          OFFSET_W     = 14;
    localparam int          BUF_ENTRIES  = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    // Both offsets fall back to this distance when never loaded.
    localparam logic [13:0] OFFSET_RESET = 14'h007F;
    localparam logic [17:0] DATA_RESET   = 18'h00000;

    // Which offset register the next load or readback targets.
    typedef enum logic {
        DCF_SEL_EMPTY = 1'b0,
        DCF_SEL_FULL  = 1'b1
    } dcf_sel_t;
endpackage

// ### hw/dcf_stream_if.sv
// Valid and ready word stream between the write buffer and the storage control.
`timescale 1ns/10ps
interface dcf_stream_if #(
    parameter int W = 18
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    // Producer end of the stream.
    modport src (output valid, output data, input ready);
    // Consumer end of the stream.
    modport snk (input valid, input data, output ready);
endinterface

// ### hw/dcf_mem.sv
// Storage array with one write port and one registered read port.
`timescale 1ns/10ps
module dcf_mem #(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 14
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Write port
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData,
    // Read port
    input  wire logic              rdEn,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [DATA_W-1:0] rdData
);
    // The array itself is never reset; only the read register is.
    logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];

    // Write side, no reset so the array maps onto block memory.
    always_ff @(posedge clk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
    end

    // Read register keeps its word between reads, so an idle port holds the last word.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData <= '0;
        end else if (rdEn) begin
            rdData <= store[rdAddr];
        end
    end
endmodule

// ### hw/dcf_skid_buf.sv
// Two-entry buffer that absorbs words while the storage cannot take them.
`timescale 1ns/10ps
module dcf_skid_buf #(
    parameter int W = 18
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Filling and draining sides
    dcf_stream_if.snk inS,
    dcf_stream_if.src outS
);
    typedef struct packed {
        logic [1:0]   cnt;
        logic         wrIdx;
        logic         rdIdx;
        logic [W-1:0] slot0;
        logic [W-1:0] slot1;
    } dcf_buf_t;

    dcf_buf_t st;
    dcf_buf_t next_st;
    logic     pushNow;
    logic     popNow;

    // Ready and valid come straight from the occupancy, which is honest at both ends.
    assign inS.ready  = (st.cnt != 2'h2);
    assign outS.valid = (st.cnt != 2'h0);
    assign outS.data  = st.rdIdx ? st.slot1 : st.slot0;
    assign pushNow    = inS.valid && inS.ready;
    assign popNow     = outS.valid && outS.ready;

    // Next occupancy, slot contents and indices.
    always_comb begin
        next_st = st;
        if (pushNow) begin
            if (st.wrIdx) begin
                next_st.slot1 = inS.data;
            end else begin
                next_st.slot0 = inS.data;
            end
            next_st.wrIdx = ~st.wrIdx;
        end
        if (popNow) begin
            next_st.rdIdx = ~st.rdIdx;
        end
        next_st.cnt = st.cnt + {1'b0, pushNow} - {1'b0, popNow};
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ### hw/dcf_fifo.sv
// Top of the buffer: pointers, flags, offset registers, readback and retransmit.
// Behaviour
// R1: Write enabled and not full stores word.
// R2: Read enabled and not empty presents word.
// R3: Output enable low drives data, else floats.
// R4: Writes ignored when full, reads when empty.
// R5: Empty buffer holds last read word.
// R6: Two fourteen-bit offsets set almost flags.
// R7: Load writes alternate empty then full offset.
// R8: Load sequence position survives leaving load.
// R9: Load readback alternates empty then full offset.
// R10: Full flag low at full, blocks writes.
// R11: Full flag changes on write edges only.
// R12: Empty flag low at empty, blocks reads.
// R13: Empty flag changes on read edges only.
// R14: Synchronous almost flags move on clock.
// R15: Almost flags follow offset thresholds.
// R16: Half flag high up to half depth.
// R17: Unloaded offsets default to 127 words.
// R18: Retransmit returns read pointer to start.
// R19: Controller idles during and after retransmit.
// R20: After retransmit reads replay, flags follow.
// R21: Retransmit only within depth, after reads.
// R22: First device of cascade ties first-load low.
// R23: Master reset empties and restores offsets.
// R24: Asynchronous almost flags follow pointers directly.
`timescale 1ns/10ps
module dcf_fifo #(
    parameter int DEPTH    = dcf_pkg::FIFO_DEPTH,
    parameter int DATA_W   = dcf_pkg::DATA_W,
    parameter int OFFSET_W = dcf_pkg::OFFSET_W
) (
    // Clock and resets
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              masterResetN,
    // Write port
    input  wire logic [DATA_W-1:0] dataIn,
    input  wire logic              writeEnableN,
    input  wire logic              loadStrobeN,
    output logic                   writeReady,
    // Read port
    input  wire logic              readEnableN,
    input  wire logic              outputEnableN,
    output logic      [DATA_W-1:0] dataOut,
    output logic                   dataOutOeN,
    // Mode and retransmit
    input  wire logic              retransmit,
    input  wire logic              flagSyncSelect,
    // Status flags, all active low
    output logic                   emptyFlagN,
    output logic                   fullFlagN,
    output logic                   halfFullFlagN,
    output logic                   progAlmostEmptyN,
    output logic                   progAlmostFullN
);
    // ------------------------------------------------------------
    // Derived sizes and elaboration checks
    // ------------------------------------------------------------
    localparam int ADDR_W = $clog2(DEPTH);
    localparam int PTR_W  = ADDR_W + 1;
    localparam logic [PTR_W-1:0] DEPTH_CNT = PTR_W'(DEPTH);
    localparam logic [PTR_W-1:0] HALF_CNT  = PTR_W'(DEPTH / 2);

    // Pointers wrap on a power of two, so the depth must be a power of two of at least four.
    if ((1 << ADDR_W) != DEPTH || DEPTH < 4) begin : g_bad_depth
        $error("Depth must be a power of two of at least four");
    end
    // Offsets wider than the address are legal; the flag compares run in int width.
    if (OFFSET_W > DATA_W || OFFSET_W > 30) begin : g_bad_offset
        $error("Offset width must fit the data word and an int compare");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PTR_W-1:0]    wrPtr;
        logic [PTR_W-1:0]    rdPtr;
        logic                emptyN;
        logic                fullN;
        logic                halfN;
        logic                paeN;
        logic                pafN;
        logic [OFFSET_W-1:0] emptyOff;
        logic [OFFSET_W-1:0] fullOff;
        dcf_pkg::dcf_sel_t   wrSel;
        dcf_pkg::dcf_sel_t   rdSel;
        logic                showOffset;
        logic [DATA_W-1:0]   offsetOut;
    } dcf_top_t;

    dcf_top_t st;
    dcf_top_t next_st;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Almost empty is asserted, low, for counts zero through the empty offset.
    function automatic logic aeFlagN(input logic [PTR_W-1:0] cnt,
                                     input logic [OFFSET_W-1:0] off);
        aeFlagN = (int'(cnt) > int'(off));
    endfunction

    // Almost full is asserted, low, from the depth minus the full offset upward.
    // The sum form keeps an offset larger than the depth from wrapping round.
    function automatic logic afFlagN(input logic [PTR_W-1:0] cnt,
                                     input logic [OFFSET_W-1:0] off);
        afFlagN = ((int'(cnt) + int'(off)) < DEPTH);
    endfunction

    // Word count held in storage, from the pointer difference.
    function automatic logic [PTR_W-1:0] wordCount(input logic [PTR_W-1:0] wp,
                                                   input logic [PTR_W-1:0] rp);
        wordCount = wp - rp;
    endfunction

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic              rst;
    logic              progWr;
    logic              progRd;
    logic              pushReq;
    logic              memWrite;
    logic              rdValid;
    logic [PTR_W-1:0]  curCount;
    logic [PTR_W-1:0]  nextCount;
    logic [DATA_W-1:0] memRdData;

    // Either reset empties the buffer; both are sampled on the clock.
    assign rst      = sys_rst || !masterResetN;                               // [R23]
    assign progWr   = !loadStrobeN && !writeEnableN;
    assign progRd   = !loadStrobeN && !readEnableN;
    // A full buffer refuses the request outright rather than queueing it.
    assign pushReq  = loadStrobeN && !writeEnableN && st.fullN;               // [R4] [R10]
    // Reads stall while retransmit is high so the pointer reload is clean.
    assign rdValid  = loadStrobeN && !readEnableN && st.emptyN && !retransmit; // [R4] [R12]
    assign curCount = wordCount(st.wrPtr, st.rdPtr);

    // ------------------------------------------------------------
    // Write buffer and storage
    // ------------------------------------------------------------
    dcf_stream_if #(.W(DATA_W)) inS ();
    dcf_stream_if #(.W(DATA_W)) outS ();

    assign inS.valid  = pushReq;
    assign inS.data   = dataIn;
    assign writeReady = inS.ready;
    // Storage accepts a buffered word whenever it is not full; the buffer covers the stall.
    assign outS.ready = st.fullN;
    assign memWrite   = outS.valid && outS.ready;                             // [R1]

    dcf_skid_buf #(.W(DATA_W)) u_buf (
        .clk  (clk),
        .rst  (rst),
        .inS  (inS),
        .outS (outS)
    );

    dcf_mem #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_mem (
        .clk    (clk),
        .rst    (rst),
        .wrEn   (memWrite),
        .wrAddr (st.wrPtr[ADDR_W-1:0]),
        .wrData (outS.data),
        .rdEn   (rdValid),                                                    // [R2] [R5]
        .rdAddr (st.rdPtr[ADDR_W-1:0]),
        .rdData (memRdData)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Pointers, offsets and the registered flags, all from the next pointer pair.
    always_comb begin
        next_st = st;
        if (memWrite) begin
            next_st.wrPtr = st.wrPtr + PTR_W'(1);
        end
        if (retransmit) begin
            next_st.rdPtr = '0;                                               // [R18] [R20]
        end else if (rdValid) begin
            next_st.rdPtr = st.rdPtr + PTR_W'(1);
        end
        // Offset loads alternate and keep their place across load strobe changes.
        if (progWr) begin
            if (st.wrSel == dcf_pkg::DCF_SEL_EMPTY) begin
                next_st.emptyOff = dataIn[OFFSET_W-1:0];                      // [R6] [R7]
                next_st.wrSel    = dcf_pkg::DCF_SEL_FULL;
            end else begin
                next_st.fullOff  = dataIn[OFFSET_W-1:0];                      // [R6] [R7]
                next_st.wrSel    = dcf_pkg::DCF_SEL_EMPTY;
            end                                                               // [R8]
        end
        // Readback walks its own alternating selection.
        if (progRd) begin
            next_st.showOffset = 1'b1;
            next_st.offsetOut  = '0;
            if (st.rdSel == dcf_pkg::DCF_SEL_EMPTY) begin
                next_st.offsetOut[OFFSET_W-1:0] = st.emptyOff;                // [R9]
                next_st.rdSel = dcf_pkg::DCF_SEL_FULL;
            end else begin
                next_st.offsetOut[OFFSET_W-1:0] = st.fullOff;                 // [R9]
                next_st.rdSel = dcf_pkg::DCF_SEL_EMPTY;
            end
        end else if (rdValid) begin
            next_st.showOffset = 1'b0;
        end
        nextCount      = wordCount(next_st.wrPtr, next_st.rdPtr);
        next_st.emptyN = (nextCount != '0);                                   // [R12] [R13]
        next_st.fullN  = (nextCount != DEPTH_CNT);                            // [R10] [R11]
        next_st.halfN  = (nextCount <= HALF_CNT);                             // [R16]
        next_st.paeN   = aeFlagN(nextCount, next_st.emptyOff);                // [R14] [R15]
        next_st.pafN   = afFlagN(nextCount, next_st.fullOff);                 // [R14] [R15]
    end

    // State register; reset leaves an empty buffer with default offsets.
    always_ff @(posedge clk) begin
        if (rst) begin
            st            <= '0;
            st.emptyN     <= 1'b0;
            st.fullN      <= 1'b1;
            st.halfN      <= 1'b1;
            st.paeN       <= 1'b0;
            st.pafN       <= 1'b1;
            st.emptyOff   <= OFFSET_W'(dcf_pkg::OFFSET_RESET);                // [R17] [R23]
            st.fullOff    <= OFFSET_W'(dcf_pkg::OFFSET_RESET);                // [R17] [R23]
            st.wrSel      <= dcf_pkg::DCF_SEL_EMPTY;
            st.rdSel      <= dcf_pkg::DCF_SEL_EMPTY;
            st.offsetOut  <= dcf_pkg::DATA_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Both sources are registers; the memory read register holds its word while empty.
    assign dataOut       = st.showOffset ? st.offsetOut : memRdData;          // [R5]
    assign dataOutOeN    = outputEnableN;                                     // [R3]
    assign emptyFlagN    = st.emptyN;
    assign fullFlagN     = st.fullN;
    assign halfFullFlagN = st.halfN;
    // The asynchronous choice is combinational and gives up glitch safety; after reset the almost full flags differ when the full offset reaches the depth.
    assign progAlmostEmptyN = flagSyncSelect ? aeFlagN(curCount, st.emptyOff) // [R24]
                                             : st.paeN;                       // [R14]
    assign progAlmostFullN  = flagSyncSelect ? afFlagN(curCount, st.fullOff)  // [R24]
                                             : st.pafN;                       // [R14]

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_store;
        memWrite ##1 1'b1;
    endsequence
    property p_store;
        s_store |-> (st.wrPtr == $past(st.wrPtr) + PTR_W'(1));
    endproperty
    a_store: assert property (p_store) else $error("Write did not advance"); // [R1]

    property p_read_adv;
        rdValid |=> (st.rdPtr == $past(st.rdPtr) + PTR_W'(1));
    endproperty
    a_read_adv: assert property (p_read_adv) else $error("Read did not advance"); // [R2]

    property p_oe;
        outputEnableN |-> dataOutOeN;
    endproperty
    a_oe: assert property (p_oe) else $error("Output driven while disabled"); // [R3]

    property p_no_over;
        !fullFlagN |-> !memWrite && !pushReq;
    endproperty
    a_no_over: assert property (p_no_over) else $error("Write while full"); // [R4] [R10]

    property p_hold_empty;
        (!emptyFlagN && !progRd && !st.showOffset) |=> $stable(dataOut);
    endproperty
    a_hold_empty: assert property (p_hold_empty) else $error("Output moved while empty"); // [R5]

    sequence s_two_loads;
        (progWr && st.wrSel == dcf_pkg::DCF_SEL_EMPTY) ##1 progWr;
    endsequence
    property p_load_order;
        s_two_loads |=> (st.fullOff == $past(dataIn[OFFSET_W-1:0]))
                        && (st.wrSel == dcf_pkg::DCF_SEL_EMPTY);
    endproperty
    a_load_order: assert property (p_load_order) else $error("Offset order broken"); // [R7]

    property p_empty_flag;
        emptyFlagN == (curCount != '0);
    endproperty
    a_empty_flag: assert property (p_empty_flag) else $error("Empty flag wrong"); // [R12]

    property p_half;
        halfFullFlagN == (curCount <= HALF_CNT);
    endproperty
    a_half: assert property (p_half) else $error("Half flag wrong"); // [R16]

    property p_default_off;
        $past(rst) |-> (st.emptyOff == dcf_pkg::OFFSET_RESET)
                       && (st.fullOff == dcf_pkg::OFFSET_RESET);
    endproperty
    a_default_off: assert property (p_default_off) else $error("Offsets not defaulted"); // [R17]

    property p_retx;
        retransmit |=> (st.rdPtr == '0) && $stable(st.wrPtr);
    endproperty
    a_retx: assert property (p_retx) else $error("Retransmit pointer wrong"); // [R18]

    property p_async_flags;
        flagSyncSelect |-> (progAlmostEmptyN == (int'(curCount) > int'(st.emptyOff)));
    endproperty
    a_async_flags: assert property (p_async_flags) else $error("Async flag wrong"); // [R24]
endmodule

// ### sim/dcf_ctrl_model.sv
// Controller model that turns bench requests into the buffer's control pins.
`timescale 1ns/10ps
module dcf_ctrl_model (
    // Resets and retransmit as seen by the controller
    input  wire logic        sysRst,
    input  wire logic        masterResetN,
    input  wire logic        retransmit,
    // Requests from the bench
    input  wire logic        reqWr,
    input  wire logic        reqRd,
    input  wire logic        reqLd,
    input  wire logic [17:0] reqWord,
    // Control pins of the buffer
    output logic             writeEnableN,
    output logic             readEnableN,
    output logic             loadStrobeN,
    output logic      [17:0] dataIn
);
    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic quiet;

    // This model is the only device of any cascade, so its first-load input counts as low.

    // Transfers are held off during reset and retransmit so no new write or read request reaches the buffer then.
    assign quiet        = sysRst | ~masterResetN | retransmit;
    assign writeEnableN = ~(reqWr & ~quiet);
    assign readEnableN  = ~(reqRd & ~quiet);
    assign loadStrobeN  = ~reqLd;
    // An idle data bus shows the inverse word, so stale data never looks like a new word.
    assign dataIn       = (reqWr | reqLd) ? reqWord : ~reqWord;
endmodule

// ### sim/tb_dual_clock_fifo_16k_x18.sv
// Self-checking bench of the buffer top with a small depth.
`timescale 1ns/10ps
module tb_dual_clock_fifo_16k_x18;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int DEPTH = 16;
    // Each row: word to write, then flags {full, almost full, half, almost empty, empty}.
    localparam logic [22:0] ROWS [16] = '{
        {18'h2A501, 5'b11101}, {18'h2A502, 5'b11101}, {18'h2A503, 5'b11111},
        {18'h2A504, 5'b11111}, {18'h2A505, 5'b11111}, {18'h2A506, 5'b11111},
        {18'h2A507, 5'b11111}, {18'h2A508, 5'b11111}, {18'h2A509, 5'b11011},
        {18'h2A50A, 5'b11011}, {18'h2A50B, 5'b10011}, {18'h2A50C, 5'b10011},
        {18'h2A50D, 5'b10011}, {18'h2A50E, 5'b10011}, {18'h2A50F, 5'b10011},
        {18'h2A510, 5'b00011}};
    logic        clk;
    logic        sysRst;
    logic        masterResetN;
    logic        outputEnableN;
    logic        retransmit;
    logic        flagSyncSelect;
    logic        reqWr;
    logic        reqRd;
    logic        reqLd;
    logic [17:0] reqWord;
    logic [17:0] dataIn;
    logic [17:0] dataOut;
    logic        writeEnableN;
    logic        readEnableN;
    logic        loadStrobeN;
    logic        writeReady;
    logic        dataOutOeN;
    logic        emptyFlagN;
    logic        fullFlagN;
    logic        halfFullFlagN;
    logic        progAlmostEmptyN;
    logic        progAlmostFullN;
    logic [4:0]  flagVec;
    int          err_total;
    int          check_count;

    // All flags gathered in the row order for one comparison.
    assign flagVec = {fullFlagN, progAlmostFullN, halfFullFlagN, progAlmostEmptyN, emptyFlagN};

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    dcf_ctrl_model dcf_ctrl_model_i (
        .sysRst(sysRst), .masterResetN(masterResetN), .retransmit(retransmit),
        .reqWr(reqWr), .reqRd(reqRd), .reqLd(reqLd), .reqWord(reqWord),
        .writeEnableN(writeEnableN), .readEnableN(readEnableN),
        .loadStrobeN(loadStrobeN), .dataIn(dataIn));

    dcf_fifo #(.DEPTH(DEPTH)) dcf_fifo_i (
        .clk(clk), .sys_rst(sysRst), .masterResetN(masterResetN),
        .dataIn(dataIn), .writeEnableN(writeEnableN), .loadStrobeN(loadStrobeN),
        .writeReady(writeReady), .readEnableN(readEnableN),
        .outputEnableN(outputEnableN), .dataOut(dataOut), .dataOutOeN(dataOutOeN),
        .retransmit(retransmit), .flagSyncSelect(flagSyncSelect),
        .emptyFlagN(emptyFlagN), .fullFlagN(fullFlagN), .halfFullFlagN(halfFullFlagN),
        .progAlmostEmptyN(progAlmostEmptyN), .progAlmostFullN(progAlmostFullN));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Requests stay raised on return, so back-to-back calls never toggle a strobe.
    task automatic wr(input logic [17:0] w);
        reqWord = w;
        reqWr = 1'b1;
        @(negedge clk);
    endtask

    task automatic rd(input logic [17:0] exp);
        reqRd = 1'b1;
        @(negedge clk);
        check("dataOut", dataOut, exp);
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // The tests need well under 200 cycles; this bound only catches a hang.
    initial begin
        #20000;
        err_total++;
        close_out();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sysRst = 1'b1;
        masterResetN = 1'b1;
        outputEnableN = 1'b0;
        retransmit = 1'b0;
        flagSyncSelect = 1'b0;
        reqWr = 1'b0;
        reqRd = 1'b0;
        reqLd = 1'b0;
        reqWord = 18'h00000;
        err_total = 0;
        check_count = 0;
        repeat (8) @(negedge clk);
        sysRst = 1'b0;
        check("flags", 18'(flagVec), 18'h0001C); // empty after reset
        check("dataOut", dataOut, 18'h00000); // output cleared
        check("writeReady", 18'(writeReady), 18'h00001); // buffer free
        done("reset");
        // Defaults read back, then loads wrap past the full offset and resume later.
        reqLd = 1'b1;
        reqRd = 1'b1;
        @(negedge clk);
        check("emptyOffset", dataOut, 18'h0007F); // default value
        @(negedge clk);
        check("fullOffset", dataOut, 18'h0007F); // default value
        reqRd = 1'b0;
        wr(18'h3C003); // empty offset, upper bits ignored
        wr(18'h3C004); // full offset
        wr(18'h3C002); // back to the empty offset
        reqWr = 1'b0;
        reqLd = 1'b0; // leave loading after three writes
        @(negedge clk);
        reqLd = 1'b1;
        wr(18'h3C005); // position kept, so this is the full offset
        reqWr = 1'b0;
        reqRd = 1'b1;
        @(negedge clk);
        check("emptyOffset", dataOut, 18'h00002); // readback order
        @(negedge clk);
        check("fullOffset", dataOut, 18'h00005); // readback order
        reqRd = 1'b0;
        reqLd = 1'b0;
        done("offsets");
        // Fill one word at a time and compare every flag against its row.
        for (int i = 0; i < DEPTH; i++) begin
            wr(ROWS[i][22:5]);
            reqWr = 1'b0;
            @(negedge clk);
            check("flags", 18'(flagVec), 18'(ROWS[i][4:0]));
        end
        wr(18'h15555); // write while full
        reqWr = 1'b0;
        @(negedge clk);
        check("fullFlagN", 18'(fullFlagN), 18'h00000); // still full
        for (int i = 0; i < DEPTH; i++) begin
            rd(ROWS[i][22:5]); // order kept, refused word absent
        end
        rd(ROWS[DEPTH - 1][22:5]); // read while empty keeps last word
        reqRd = 1'b0;
        check("emptyFlagN", 18'(emptyFlagN), 18'h00000); // empty again
        done("rows");
        // The pin enable must track the output-enable input in both states.
        outputEnableN = 1'b1;
        #1;
        check("dataOutOeN", 18'(dataOutOeN), 18'h00001); // pins released
        @(negedge clk);
        outputEnableN = 1'b0;
        #1;
        check("dataOutOeN", 18'(dataOutOeN), 18'h00000); // pins driven
        @(negedge clk);
        done("enable");
        // Master reset, then retransmit after two of four words were read.
        masterResetN = 1'b0;
        @(negedge clk);
        masterResetN = 1'b1;
        flagSyncSelect = 1'b1;
        check("emptyFlagN", 18'(emptyFlagN), 18'h00000); // emptied
        for (int i = 0; i < 4; i++) begin
            wr(ROWS[i][22:5]);
        end
        reqWr = 1'b0;
        repeat (2) @(negedge clk);
        rd(ROWS[0][22:5]); // first word
        rd(ROWS[1][22:5]); // second word
        reqRd = 1'b0;
        retransmit = 1'b1; // within depth and after reads
        @(negedge clk);
        retransmit = 1'b0;
        repeat (2) @(negedge clk); // idle while the pointer settles
        check("progAlmostEmptyN", 18'(progAlmostEmptyN), 18'h00000); // default offset
        check("progAlmostFullN", 18'(progAlmostFullN), 18'h00000); // offset past depth
        for (int i = 0; i < 4; i++) begin
            rd(ROWS[i][22:5]); // replay from the first location
        end
        reqRd = 1'b0;
        check("emptyFlagN", 18'(emptyFlagN), 18'h00000); // pointers meet
        done("retransmit");
        close_out();
    end
endmodule
